// >>> rtl/cpd_params.svh
// constant definitions for the configuration prom serial reader block
// assumes: included by the design files by bare name
`ifndef CPD_PARAMS_SVH
`define CPD_PARAMS_SVH

// ==========================================================================
// storage
`define CPD_TOTAL_BITS 2097152
// configuration image length: slightly under the first megabit
`define CPD_CFG_BITS 1040000

// ==========================================================================
// jumper codes and boot mode
`define CPD_JP_DEFAULT 2'h0
`define CPD_JP_FLASH 2'h1
`define CPD_MODE_MSER 3'h0

// ==========================================================================
// synchroniser width: done, init, read clock, jumper[1:0], mode[2:0]
`define CPD_SYNC_W 8

`endif

// >>> rtl/cpd_pkg.sv
// types shared by the configuration prom serial reader block
// assumes: nothing beyond a SystemVerilog compiler
package cpd_pkg;

	// ======================================================================
	// jumper option, one-hot
	typedef enum logic [2:0] {
		CPD_OPT_DEFAULT = 3'b001,
		CPD_OPT_FLASH = 3'b010,
		CPD_OPT_OFF = 3'b100
	} cpd_opt_type;

	// ======================================================================
	// pins from the fpga side, asynchronous to CLK_I
	typedef struct packed {
		logic done;
		logic init;
		logic rd_clk;
	} cpd_cfg_pins_type;

	// ======================================================================
	// prom pin outputs
	typedef struct packed {
		logic en;
		logic low_power;
		logic dout;
		logic dout_oe_n;
	} cpd_flash_out_type;

endpackage : cpd_pkg

// >>> rtl/cpd_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
// assumes: inputs come from pins outside the CLK_I domain
`timescale 1ns/100ps
module cpd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ======================================================================
	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;

endmodule : cpd_sync

// >>> rtl/cpd_prom.sv
// serial configuration prom: boots the fpga and serves user data
// assumes: the read clock net is shared by the fpga configuration clock
// and the user read clock; all pins except the programming port are asynchronous to CLK_I
`timescale 1ns/100ps
`include "cpd_params.svh"

module cpd_prom #(
	parameter int TOTAL_BITS = `CPD_TOTAL_BITS,
	parameter int CFG_BITS = `CPD_CFG_BITS,
	parameter int PTR_W = $clog2(`CPD_TOTAL_BITS)
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire cpd_pkg::cpd_cfg_pins_type PINS_I,
	input wire logic [1:0] JUMPER_I,
	input wire logic [2:0] BOOT_MODE_PINS_I,
	input wire logic PRG_WE_I,
	input wire logic [PTR_W-1:0] PRG_ADDR_I,
	input wire logic PRG_BIT_I,
	output cpd_pkg::cpd_flash_out_type FLASH_O,
	output logic BOOT_MS_O,
	output logic USER_AREA_O
);
	import cpd_pkg::*;

	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(TOTAL_BITS - 1);
	localparam logic [PTR_W-1:0] PTR_USER = PTR_W'(CFG_BITS);

	// ======================================================================
	// pin synchronisation
	logic [`CPD_SYNC_W-1:0] sync_in;
	logic [`CPD_SYNC_W-1:0] sync_out;
	logic done_s;
	logic init_s;
	logic clk_s;
	logic [1:0] jumper_s;
	logic [2:0] mode_s;

	assign sync_in = {PINS_I.done, PINS_I.init, PINS_I.rd_clk,
		JUMPER_I, BOOT_MODE_PINS_I};

	cpd_sync #(
		.WIDTH(`CPD_SYNC_W)
	) u_sync (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.d_i(sync_in),
		.q_o(sync_out)
	);

	assign {done_s, init_s, clk_s, jumper_s, mode_s} = sync_out;

	// ======================================================================
	// storage: written by the programming port, never reset
	logic [TOTAL_BITS-1:0] mem_ff;

	always_ff @(posedge CLK_I) begin
		if (PRG_WE_I) begin
			mem_ff[PRG_ADDR_I] <= PRG_BIT_I;
		end
	end

	// ======================================================================
	// option decode and enable
	cpd_opt_type opt_ff;
	cpd_opt_type nxt_opt;
	logic en_ff;
	logic nxt_en;
	logic clk_d_ff;
	logic nxt_clk_d;
	logic rise;

	always_comb begin
		nxt_clk_d = clk_s;
		if (jumper_s == `CPD_JP_DEFAULT) begin
			nxt_opt = CPD_OPT_DEFAULT;
		end else if (jumper_s == `CPD_JP_FLASH) begin
			nxt_opt = CPD_OPT_FLASH;
		end else begin
			nxt_opt = CPD_OPT_OFF;
		end
		unique case (nxt_opt)
			CPD_OPT_DEFAULT: begin
				nxt_en = !done_s;
			end
			CPD_OPT_FLASH: begin
				nxt_en = 1'b1;
			end
			CPD_OPT_OFF: begin
				nxt_en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			opt_ff <= CPD_OPT_DEFAULT;
			en_ff <= 1'b0;
			clk_d_ff <= 1'b0;
		end else begin
			opt_ff <= nxt_opt;
			en_ff <= nxt_en;
			clk_d_ff <= nxt_clk_d;
		end
	end

	// read clock sampled at 20 MHz; pulses must be several cycles wide
	assign rise = clk_s && !clk_d_ff;

	// ======================================================================
	// read position and serial data
	logic [PTR_W-1:0] ptr_ff;
	logic [PTR_W-1:0] nxt_ptr;
	logic dout_ff;
	logic nxt_dout;
	logic oe_n_ff;
	logic nxt_oe_n;
	logic lp_ff;
	logic nxt_lp;
	logic boot_ff;
	logic nxt_boot;
	logic user_ff;
	logic nxt_user;

	always_comb begin
		nxt_ptr = ptr_ff;
		if (!init_s) begin
			nxt_ptr = '0;
		end else if (nxt_en && rise && ptr_ff != PTR_LAST) begin
			// position steps by one on each enabled read clock rise while init stays high, and holds once it reaches the last bit
			nxt_ptr = ptr_ff + PTR_W'(1);
		end
		nxt_dout = mem_ff[nxt_ptr];
		nxt_oe_n = !nxt_en;
		nxt_lp = !nxt_en;
		nxt_boot = (mode_s == `CPD_MODE_MSER);
		nxt_user = (nxt_ptr >= PTR_USER);
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ptr_ff <= '0;
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			lp_ff <= 1'b1;
			boot_ff <= 1'b0;
			user_ff <= 1'b0;
		end else begin
			ptr_ff <= nxt_ptr;
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
			lp_ff <= nxt_lp;
			boot_ff <= nxt_boot;
			user_ff <= nxt_user;
		end
	end

	// one driver for the whole struct rather than one per field
	assign FLASH_O = '{en: en_ff, low_power: lp_ff, dout: dout_ff,
		dout_oe_n: oe_n_ff};
	assign BOOT_MS_O = boot_ff;
	assign USER_AREA_O = user_ff;

	// ======================================================================
	// assertions
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);

	dflt_boot_en_a: assert property (
		(jumper_s == `CPD_JP_DEFAULT && !done_s) |=> (en_ff && !lp_ff))
		else $error("prom not enabled during configuration");

	dflt_done_off_a: assert property (
		(jumper_s == `CPD_JP_DEFAULT && done_s) |=> (!en_ff && lp_ff))
		else $error("prom not in low power after done");

	dflt_no_data_a: assert property (
		(opt_ff == CPD_OPT_DEFAULT && $past(done_s)) |-> oe_n_ff)
		else $error("data driven after boot in default option");

	flash_always_a: assert property (
		(jumper_s == `CPD_JP_FLASH) |=> (en_ff && !oe_n_ff))
		else $error("prom disabled in flash read option");

	ptr_hold_a: assert property (
		(init_s && !rise) |=> $stable(ptr_ff))
		else $error("read position moved without a pulse");

	ptr_clear_a: assert property (
		!init_s |=> (ptr_ff == '0))
		else $error("read position not reset by init low");

	ptr_step_a: assert property (
		(init_s && rise && nxt_en && ptr_ff != PTR_LAST)
		|=> ptr_ff == $past(ptr_ff) + PTR_W'(1))
		else $error("read position did not step by one");

	data_bit_a: assert property (
		($past(RSTN_I) && !$past(PRG_WE_I)) |-> dout_ff == mem_ff[ptr_ff])
		else $error("serial data does not match read position");

	user_area_a: assert property (
		(USER_AREA_O == (ptr_ff >= PTR_USER)) && (ptr_ff <= PTR_LAST))
		else $error("user area flag or position range wrong");

	jp_off_a: assert property (
		(jumper_s != `CPD_JP_DEFAULT && jumper_s != `CPD_JP_FLASH)
		|=> (!en_ff && oe_n_ff && lp_ff))
		else $error("prom enabled with jumper removed");

	boot_mode_a: assert property (
		RSTN_I |=> (BOOT_MS_O == ($past(mode_s) == `CPD_MODE_MSER)))
		else $error("master serial boot flag wrong");

	cfg_done_c: cover property (
		(opt_ff == CPD_OPT_DEFAULT && en_ff) ##[1:1000] lp_ff);
	flash_read_c: cover property (
		(opt_ff == CPD_OPT_FLASH && USER_AREA_O && rise));
	jp_off_c: cover property (opt_ff == CPD_OPT_OFF && init_s);

endmodule : cpd_prom

// >>> rtl/cpd_tb_placeholder_none.sv
// intentionally empty of logic: no additional design unit
`timescale 1ns/100ps

// >>> tb/cpd_reader.sv
// fpga user logic model: pulses the read clock, takes one bit per pulse
// assumes: caller enters read_bit just after a CLK_I edge
`timescale 1ns/100ps
module cpd_reader (
	input wire logic clk_i,
	input wire logic dout_i,
	output logic rd_clk_o
);
	// ======================================================================
	// read clock stands still between reads
	initial rd_clk_o = 1'b0;
	// four edges high, four low: one 400 ns link period per bit
	task automatic read_bit(output logic b);
		rd_clk_o = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 rd_clk_o = 1'b0;
		repeat (4) @(posedge clk_i);
		// new bit lands three edges after the rise, long before here
		#1 b = dout_i;
	endtask : read_bit
endmodule : cpd_reader

// >>> tb/cpd_prom_tb.sv
// self-checking bench for the serial prom block
// assumes: cpd_pkg compiled, prom shrunk to 256 bits with a 100 bit image
`timescale 1ns/100ps
module cpd_prom_tb;
	import cpd_pkg::*;
	localparam int TB = 256;
	localparam int CB = 100;
	logic clk, rstn, done, init, rd, we, pb, ms, ua, b;
	logic [1:0] jp;
	logic [2:0] mode;
	logic [7:0] adr;
	cpd_flash_out_type fo;
	logic mem [TB];
	int bad_count, num_checks;

	cpd_prom #(.TOTAL_BITS(TB), .CFG_BITS(CB), .PTR_W(8)) dut (
		.CLK_I(clk), .RSTN_I(rstn), .PINS_I({done, init, rd}),
		.JUMPER_I(jp), .BOOT_MODE_PINS_I(mode), .PRG_WE_I(we),
		.PRG_ADDR_I(adr), .PRG_BIT_I(pb), .FLASH_O(fo),
		.BOOT_MS_O(ms), .USER_AREA_O(ua));
	cpd_reader rdr (.clk_i(clk), .dout_i(fo.dout), .rd_clk_o(rd));

	// ======================================================================
	// helpers
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// enable, low power, output enable (low = driving) per option
	function automatic logic [2:0] exp_flags(input logic [1:0] j,
		input logic d);
		logic e;
		e = (j == 2'h0) ? !d : (j == 2'h1);
		return {e, !e, !e};
	endfunction : exp_flags
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// pin changes show three edges later; the fourth leaves margin
	task automatic pin_wait;
		repeat (4) @(posedge clk);
		#1;
	endtask : pin_wait
	task automatic rdb(input int p);
		rdr.read_bit(b);
		chk(b, mem[p]);
	endtask : rdb

	// ======================================================================
	// clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		bad_count++;
		summarize();
	end
	initial begin
		rstn = 1'b0; done = 1'b0; init = 1'b0; jp = 2'h0; mode = 3'h0;
		we = 1'b0; adr = 8'h00; pb = 1'b0;
		void'($urandom(32'hba6b9ca2));
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		for (int i = 0; i < TB; i++) begin
			mem[i] = 1'($urandom);
			we = 1'b1;
			adr = i[7:0];
			pb = mem[i];
			@(posedge clk);
			#1;
		end
		we = 1'b0;
		mode = 3'(1 + $urandom % 7);
		pin_wait();
		chk(ms, 1'b0);
		mode = 3'h0;
		init = 1'b1;
		pin_wait();
		chk({fo.en, fo.low_power, fo.dout_oe_n, ms},
			{exp_flags(jp, done), 1'b1});
		chk(fo.dout, mem[0]);
		for (int i = 1; i < CB; i++) rdb(i);
		chk(ua, 1'b0);
		done = 1'b1;
		pin_wait();
		chk({fo.en, fo.low_power, fo.dout_oe_n}, exp_flags(jp, done));
		chk(fo.dout_oe_n, 1'b1);
		// pulse while disabled must not move the read position
		rdr.read_bit(b);
		jp = 2'h1;
		pin_wait();
		chk({fo.en, fo.low_power, fo.dout_oe_n}, exp_flags(jp, done));
		chk(fo.dout, mem[CB-1]);
		for (int i = 0; i < 16; i++) rdb(CB + i);
		chk(ua, 1'b1);
		for (int j = 2; j < 4; j++) begin
			jp = j[1:0];
			pin_wait();
			chk(fo.en, 1'b0);
		end
		jp = 2'h1;
		init = 1'b0;
		pin_wait();
		chk(fo.dout, mem[0]);
		init = 1'b1;
		pin_wait();
		for (int i = 1; i < TB; i++) rdb(i);
		// last bit holds when pulsed past the end
		rdb(TB - 1);
		summarize();
	end
endmodule : cpd_prom_tb
